// [spi_port.v]
// Byte-wide serial port, master or slave, with select handling and error flags.
// Assumes an AHB-Lite master on hclk and pins asynchronous to hclk.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "spi_map.vh"
module spi_port #(
  parameter [7:0] HALF_BASE = `HALF_BASE
)(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        serial_clock_i,
  output reg         serial_clock_o,
  output reg         serial_clock_oe,
  input  wire        mosi_i,
  output wire        mosi_o,
  output reg         mosi_oe,
  input  wire        miso_i,
  output wire        miso_o,
  output reg         miso_oe,
  input  wire        select_n_i,
  output reg         select_n_o,
  output reg         select_n_oe,
  output reg         irq
);
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_SETUP = 2'd1;
  localparam [1:0] ST_SHIFT = 2'd2;
  localparam [1:0] ST_HOLD  = 2'd3;

  reg  [7:0] ctrl_q;
  reg  [7:0] status_q;
  reg  [1:0] irqen_q;
  reg  [7:0] shift_q;
  reg  [7:0] rbuf_q;
  reg        rxbit_q;
  reg        dout_q;
  reg  [3:0] cnt_q;
  reg  [1:0] state_q;
  reg  [7:0] half_q;
  reg        sclk_prev_q;
  reg        wr_pend_q;
  reg  [7:0] wr_idx_q;
  wire [3:0] pins_s;
  wire       sclk_s;
  wire       sel_n_s;
  wire       mosi_s;
  wire       miso_s;

  // Pins pass two flip-flops before any logic reads them
  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pins_in   ({serial_clock_i, select_n_i, mosi_i, miso_i}),
    .reset_val (4'hf),
    .pins_sync (pins_s)
  );
  assign sclk_s  = pins_s[3];
  assign sel_n_s = pins_s[2];
  assign mosi_s  = pins_s[1];
  assign miso_s  = pins_s[0];

  // Serial data leaves from one flop; enables decide which pin carries it
  assign mosi_o = dout_q;
  assign miso_o = dout_q;

  // Bit presented on the line for the current shifter contents
  function out_bit;
    input [7:0] sh;
    input       lsb;
    begin
      out_bit = lsb ? sh[0] : sh[7];
    end
  endfunction

  // Shift one received bit in from the far end of the shifter
  function [7:0] shift_in;
    input [7:0] sh;
    input       lsb;
    input       b;
    begin
      shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    end
  endfunction

  // Pad the missing bits of an aborted byte with ones
  function [7:0] fill_ones;
    input [7:0] sh;
    input       lsb;
    input [3:0] n;
    integer     i;
    reg   [7:0] t;
    begin
      t = sh;
      for (i = 0; i < 8; i = i + 1) begin
        if (i < n)
          t = shift_in(t, lsb, 1'b1);
      end
      fill_ones = t;
    end
  endfunction

  wire       en     = ctrl_q[`CTL_EN];
  wire       master = ctrl_q[`CTL_ROLE];
  wire       lsb    = ctrl_q[`CTL_LSB];
  wire       cpol   = ctrl_q[`CTL_CPOL];
  wire       cpha   = ctrl_q[`CTL_CPHA];
  wire       fdd    = status_q[`ST_FDD];
  wire [7:0] half_len = HALF_BASE << ctrl_q[`CTL_RATE_HI:`CTL_RATE_LO];
  wire       m_tick   = (half_q == half_len - 8'h01);

  // Bus address phase accepted
  wire       addr_ok  = hsel & htrans[1] & hready;
  wire [7:0] a_idx    = haddr[9:2];
  wire       wr_data  = wr_pend_q & (wr_idx_q == `IDX_DATA);
  wire       wr_ctrl  = wr_pend_q & (wr_idx_q == `IDX_CTRL);
  wire       wr_stat  = wr_pend_q & (wr_idx_q == `IDX_STATUS);
  wire       wr_irqen = wr_pend_q & (wr_idx_q == `IDX_IRQEN);

  // Slave role: select is always an active-low input
  wire       slv_act   = en & ~master & ~sel_n_s;                                  // RULE1
  wire       slv_edge  = slv_act & (sclk_s != sclk_prev_q);
  wire       slv_lead  = slv_edge & (sclk_s != cpol);
  wire       slv_trail = slv_edge & (sclk_s == cpol);
  wire       m_edge    = (state_q == ST_SHIFT) & m_tick;
  wire       m_lead    = m_edge & ~cnt_q[0];
  wire       m_trail   = m_edge & cnt_q[0];
  wire       lead      = master ? m_lead : slv_lead;
  wire       trail     = master ? m_trail : slv_trail;
  wire       din       = master ? miso_s : mosi_s;
  wire [7:0] sh_next   = shift_in(shift_q, lsb, cpha ? din : rxbit_q);
  wire       byte_done = trail & (cnt_q == 4'hf);

  // Busy windows for collision detection, both roles
  wire       slv_busy  = slv_act & ((cnt_q != 4'h0) | ~cpha);                     // RULE10
  wire       busy      = (master & (state_q != ST_IDLE)) | slv_busy;
  wire       write_collision_flag_ev   = wr_data & busy;                                          // RULE8
  wire       load_ev   = wr_data & ~busy;                                         // RULE7

  // Mode fault: another master pulls our select while fault detect is on
  wire       fault_ev  = en & master & ~fdd & ~sel_n_s;                            // RULE2 RULE5

  // Slave deselected mid byte
  wire       slv_abort = en & ~master & sel_n_s & (cnt_q != 4'h0);

  // Any change to control bits 5:0 while enabled, or clearing enable, throws the transfer away
  wire       cfg_abort = wr_ctrl & en &
                         ((hwdata[5:0] != ctrl_q[5:0]) | ~hwdata[`CTL_EN]);

  // AHB-Lite slave: zero wait states, always OKAY, reads registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok & hwrite;
      wr_idx_q  <= a_idx;
      if (addr_ok & ~hwrite) begin
        case (a_idx)
          `IDX_CTRL:   hrdata <= {24'h00_0000, ctrl_q};
          `IDX_STATUS: hrdata <= {24'h00_0000, status_q[7:3], 3'h0};
          `IDX_DATA:   hrdata <= {24'h00_0000, rbuf_q};                          // RULE12
          `IDX_IRQEN:  hrdata <= {30'h0000_0000, irqen_q};
          default:     hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and interrupt enable registers; fault clears master and enable at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= `CTL_RESET;
      irqen_q <= 2'b00;
    end else begin
      if (wr_ctrl)
        ctrl_q <= hwdata[7:0];
      if (fault_ev) begin
        ctrl_q[`CTL_ROLE] <= 1'b0;                                                // RULE5
        ctrl_q[`CTL_EN]   <= 1'b0;
      end
      if (wr_irqen)
        irqen_q <= hwdata[1:0];
    end
  end

  // Status flags: a zero written clears, a hardware set in the same cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= `STATUS_RESET;
    end else begin
      if (wr_stat) begin
        status_q[`ST_DONE] <= status_q[`ST_DONE] & hwdata[`ST_DONE];              // RULE16
        status_q[`ST_COLL] <= status_q[`ST_COLL] & hwdata[`ST_COLL];              // RULE11
        status_q[`ST_OVF]  <= status_q[`ST_OVF] & hwdata[`ST_OVF];
        status_q[`ST_MFLT] <= status_q[`ST_MFLT] & hwdata[`ST_MFLT];
        status_q[`ST_FDD]  <= hwdata[`ST_FDD];
      end
      if (byte_done & ~status_q[`ST_DONE])
        status_q[`ST_DONE] <= 1'b1;                                               // RULE14
      if (byte_done & status_q[`ST_DONE])
        status_q[`ST_OVF] <= 1'b1;                                                // RULE13
      if (write_collision_flag_ev)
        status_q[`ST_COLL] <= 1'b1;                                               // RULE8
      if (fault_ev)
        status_q[`ST_MFLT] <= 1'b1;                                               // RULE5
    end
  end

  // Read buffer keeps the old byte on overrun
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rbuf_q <= 8'h00;
    else if (byte_done & ~status_q[`ST_DONE])
      rbuf_q <= sh_next;                                                          // RULE12 RULE13
  end

  // Shift engine shared by both roles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q     <= 8'h00;
      rxbit_q     <= 1'b0;
      dout_q      <= 1'b0;
      cnt_q       <= 4'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      if (fault_ev | cfg_abort | ~en) begin
        cnt_q <= 4'h0;
      end else if (slv_abort) begin
        // Remaining receive bits become ones, then idle
        shift_q <= fill_ones(shift_q, lsb, 4'h8 - {1'b0, cnt_q[3:1]});           // RULE18
        cnt_q   <= 4'h0;
      end else if (load_ev) begin
        // Collision writes never reach here, so the running byte is untouched
        shift_q <= hwdata[7:0];                                                   // RULE7 RULE9
        dout_q  <= out_bit(hwdata[7:0], lsb);
        cnt_q   <= 4'h0;
      end else begin
        if (lead) begin
          if (cpha)
            dout_q <= out_bit(shift_q, lsb);
          else
            rxbit_q <= din;
          cnt_q <= cnt_q + 4'h1;
        end
        if (trail) begin
          shift_q <= sh_next;
          if (!cpha)
            dout_q <= out_bit(sh_next, lsb);
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  // Master sequencer: select setup, sixteen clock edges, select hold
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q        <= ST_IDLE;
      half_q         <= 8'h00;
      serial_clock_o <= 1'b0;
    end else begin
      if (fault_ev | cfg_abort | ~en | ~master) begin
        state_q        <= ST_IDLE;
        half_q         <= 8'h00;
        serial_clock_o <= cpol;
      end else begin
        case (state_q)
          ST_IDLE: begin
            serial_clock_o <= cpol;
            half_q         <= 8'h00;
            if (load_ev)
              state_q <= ST_SETUP;                                                // RULE17
          end
          ST_SETUP: begin
            half_q <= m_tick ? 8'h00 : half_q + 8'h01;
            if (m_tick)
              state_q <= ST_SHIFT;                                                // RULE20
          end
          ST_SHIFT: begin
            half_q <= m_tick ? 8'h00 : half_q + 8'h01;
            if (m_tick) begin
              serial_clock_o <= ~serial_clock_o;
              if (cnt_q == 4'hf)
                state_q <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            half_q <= m_tick ? 8'h00 : half_q + 8'h01;
            if (m_tick)
              state_q <= ST_IDLE;                                                 // RULE20
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Pin direction and select output; select is released whenever it is not ours
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_clock_oe <= 1'b0;
      mosi_oe         <= 1'b0;
      miso_oe         <= 1'b0;
      select_n_o      <= 1'b1;
      select_n_oe     <= 1'b0;
    end else begin
      serial_clock_oe <= en & master;
      mosi_oe         <= en & master;
      miso_oe         <= slv_act;                                                 // RULE1
      select_n_oe     <= en & master & fdd & ctrl_q[`CTL_AUTO];                   // RULE3 RULE4
      select_n_o      <= (state_q == ST_IDLE);                                    // RULE3
    end
  end

  // One shared interrupt request, level while the done, mode fault or overrun flag stands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= irqen_q[`IE_PORT] & irqen_q[`IE_GLOBAL] &
             (status_q[`ST_DONE] | status_q[`ST_MFLT] | status_q[`ST_OVF]);       // RULE15
  end

  // hsize is accepted but only word transfers are supported
  wire unused_ok = &{hsize, haddr[31:10], haddr[1:0], htrans[0], hwdata[31:8]};
endmodule
`default_nettype wire

// [spi_map.vh]
// Register map, field positions and reset values of the serial port block.
// Assumes an AHB-Lite word bus; byte address of a register is four times its index.
//
// Summary of operation
// RULE1 - Slave role: select pin is always select input
// RULE2 - Master, fault detect on: select monitors faults
// RULE3 - Master, auto select: pin low during transfers
// RULE4 - Master, no fault, no output: pin released
// RULE5 - Fault: clear master and enable, set flag
// RULE6 - Others never pull our select while master
// RULE7 - Single transmit buffer: write loads shifter directly
// RULE8 - Write during transfer sets write collision flag
// RULE9 - Collision keeps current shift, drops new byte
// RULE10 - Slave write while receiving is a collision
// RULE11 - Write collision flag cleared only by software
// RULE12 - Completed byte copied into separate read buffer
// RULE13 - Byte while done still set: overrun, drop
// RULE14 - Done flag set when byte completes
// RULE15 - Interrupt when flag set and both enables
// RULE16 - Flags stay set until software clears them
// RULE17 - Master data write starts full duplex shifting
// RULE18 - Slave deselect mid byte: fill ones, idle
// RULE19 - Software disables port before changing configuration
// RULE20 - Auto select spans all clock edges
`ifndef SPI_MAP_VH
`define SPI_MAP_VH

// Register indices
`define IDX_CTRL       8'hf3
`define IDX_STATUS     8'hf4
`define IDX_DATA       8'hf5
`define IDX_IRQEN      8'hf6

// Control register fields
`define CTL_AUTO       7
`define CTL_EN         6
`define CTL_LSB        5
`define CTL_ROLE       4
`define CTL_CPOL       3
`define CTL_CPHA       2
`define CTL_RATE_HI    1
`define CTL_RATE_LO    0
`define CTL_RESET      8'h00

// Status register fields
`define ST_DONE        7
`define ST_COLL        6
`define ST_OVF         5
`define ST_MFLT        4
`define ST_FDD         3
`define STATUS_RESET   8'h00

// Interrupt enable fields
`define IE_PORT        0
`define IE_GLOBAL      1

// Serial clock half period at rate 0, in hclk cycles
`define HALF_BASE      8'h04

`endif

// [pin_sync.v]
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to hclk; the result is read only after stage two.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 4
)(
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] pins_in,
  input  wire [WIDTH-1:0] reset_val,
  output reg  [WIDTH-1:0] pins_sync
);
  reg [WIDTH-1:0] meta_q;

  // Reset loads all ones; idle levels of select and clock are handled by the user
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q    <= {WIDTH{1'b1}};
      pins_sync <= {WIDTH{1'b1}};
    end else begin
      meta_q    <= pins_in;
      pins_sync <= meta_q;
    end
  end

  // reset_val is kept for interface symmetry and not used inside
  wire unused_ok = &reset_val;
endmodule
`default_nettype wire

// [spi_port_sva.sv]
// Checker for the serial port: select framing, clock timing, pin enables, bus answer.
// Assumes a bench that never reconfigures mid-byte; any rate setting will do.
`timescale 1ns/10ps
`default_nettype none
module spi_port_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serial_clock_o,
  input wire logic serial_clock_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic select_n_o,
  input wire logic select_n_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] edges_q;
  // Clock toggles inside one select window; a counter keeps the property short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) edges_q <= 5'h00;
    else if (select_n_o) edges_q <= 5'h00;
    else if ($changed(serial_clock_o)) edges_q <= edges_q + 5'h01;
  end
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready or not okay");
  property p_slave_sel; !serial_clock_oe |-> !select_n_oe; endproperty
  a_slave_sel: assert property (p_slave_sel)
    else $error("select driven outside master role");
  property p_miso; miso_oe |-> !serial_clock_oe && !select_n_oe; endproperty
  a_miso: assert property (p_miso)
    else $error("slave data out while master");
  property p_mosi; mosi_oe == serial_clock_oe; endproperty
  a_mosi: assert property (p_mosi)
    else $error("master data and clock enables disagree");
  property p_span; $fell(select_n_o) |-> !select_n_o [*8]; endproperty
  a_span: assert property (p_span)
    else $error("select window too short");
  property p_setup; $fell(select_n_o) |-> $stable(serial_clock_o) [*2]; endproperty
  a_setup: assert property (p_setup)
    else $error("clock edge too soon after select");
  property p_hold;
    $rose(select_n_o) |-> $past(serial_clock_o, 1) == $past(serial_clock_o, 2);
  endproperty
  a_hold: assert property (p_hold)
    else $error("select released right after a clock edge");
  property p_edges; $rose(select_n_o) |-> edges_q == 5'h10; endproperty
  a_edges: assert property (p_edges)
    else $error("byte did not carry sixteen clock edges");
  property p_idle;
    select_n_o && $past(select_n_o) && serial_clock_oe && $past(serial_clock_oe)
      |-> $stable(serial_clock_o);
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock moved while port idle");
endmodule
bind spi_port spi_port_sva chk (.hclk, .hresetn, .hreadyout, .hresp, .serial_clock_o,
  .serial_clock_oe, .mosi_oe, .miso_oe, .select_n_o, .select_n_oe);
`default_nettype wire

// [spi_partner.sv]
// Far-side slave device, clock format 0, most significant bit first.
// Assumes the resolved clock, select and data lines of the bus.
`timescale 1ns/10ps
`default_nettype none
module spi_partner (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  logic [7:0] sh;
  // Select is only watched here; this device never pulls it low
  initial begin
    miso = 1'b1;
    rx = 8'h00;
  end
  // First bit must stand before the first clock edge
  always @(negedge sel_n) begin
    sh = tx;
    miso = tx[7];
  end
  // Sample on the leading edge, shift on the trailing one
  always @(posedge sclk) if (!sel_n) rx = {rx[6:0], mosi};
  always @(negedge sclk) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // A released line must not keep showing a stale bit
  always @(posedge sel_n) miso = ~miso;
endmodule
`default_nettype wire

// [spi_select_fault_errors_tb.sv]
// Testbench for the serial port: select modes, mode fault, collision, overrun, interrupt.
// Assumes the far-side slave model and register indices from the map header.
`timescale 1ns/10ps
`default_nettype none
`include "spi_map.vh"
module spi_select_fault_errors_tb;
  logic hclk, hresetn, hsel, hwrite, tb_sclk, tb_mosi, tb_sel;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ptx, b, old, mrx;
  wire [7:0] prx;
  wire [31:0] hrdata;
  wire hreadyout, hresp, serial_clock_o, serial_clock_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire select_n_o, select_n_oe, irq, p_miso;
  int mismatches, checks_done, cyc;
  logic [7:0] sent_q[$];
  // Wire levels resolved from the port's enables; the bench or partner drives otherwise
  wire sclk_w = serial_clock_oe ? serial_clock_o : tb_sclk;
  wire sel_w = select_n_oe ? select_n_o : tb_sel;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  spi_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_clock_i(sclk_w),
    .serial_clock_o, .serial_clock_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe,
    .miso_i(miso_w), .miso_o, .miso_oe, .select_n_i(sel_w), .select_n_o,
    .select_n_oe, .irq);
  spi_partner slave (.sclk(sclk_w), .sel_n(sel_w), .mosi(mosi_w), .tx(ptx),
    .miso(p_miso), .rx(prx));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One single word transfer; address phase held until ready, then data phase
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rr(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 8'h00);
    chk(rd, e);
  endtask
  task automatic wflag(input int n);
    do bus(1'b0, `IDX_STATUS, 8'h00); while (rd[n] !== 1'b1);
  endtask
  // Outside master: 160 ns link clock, format 0; n below 8 aborts the byte
  task automatic slv(input logic [7:0] v, input int n);
    #7 tb_sel = 1'b0;
    tb_mosi = v[7];
    for (int k = 0; k < n; k++) begin
      #80 tb_sclk = 1'b1;
      mrx = {mrx[6:0], miso_w};
      #80 tb_sclk = 1'b0;
      // Next bit goes out on the trailing edge, as format 0 asks
      if (k < 7) tb_mosi = v[6-k];
    end
    #80 tb_sel = 1'b1;
    tb_mosi = ~tb_mosi;
    #160;
  endtask
  initial begin
    {hresetn, hsel, hwrite, tb_sclk, tb_mosi} = 5'h00;
    {haddr, hwdata, htrans, ptx} = 74'h0;
    hsize = 3'h2;
    tb_sel = 1'b1;
    void'($urandom(32'ha009));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rr(`IDX_CTRL, 32'h0);
    rr(`IDX_STATUS, 32'h0);
    rr(`IDX_IRQEN, 32'h0);
    rr(8'h10, 32'h0);
    wr(`IDX_STATUS, 8'h08);
    wr(`IDX_CTRL, 8'hd0);
    // Back-to-back data writes: the second one lands in the select setup, before the first clock edge
    b = $urandom;
    ptx = $urandom;
    sent_q.push_back(b);
    wr(`IDX_DATA, b);
    wr(`IDX_DATA, ~b);
    chk(sel_w, 32'h0);
    wflag(7);
    chk(prx, sent_q.pop_front());
    rr(`IDX_DATA, ptx);
    rr(`IDX_STATUS, 32'hc8);
    chk(sel_w, 32'h1);
    // Half rate for the next byte; the port is disabled around the change
    wr(`IDX_CTRL, 8'h90);
    wr(`IDX_CTRL, 8'hd1);
    // Second byte while done is still set: old byte must survive
    old = ptx;
    ptx = $urandom;
    b = $urandom;
    sent_q.push_back(b);
    wr(`IDX_DATA, b);
    wflag(5);
    chk(prx, sent_q.pop_front());
    rr(`IDX_DATA, old);
    rr(`IDX_STATUS, 32'he8);
    wr(`IDX_IRQEN, 8'h03);
    rr(`IDX_IRQEN, 32'h3);
    chk(irq, 32'h1);
    wr(`IDX_IRQEN, 8'h02);
    rr(`IDX_IRQEN, 32'h2);
    chk(irq, 32'h0);
    wr(`IDX_STATUS, 8'h08);
    wr(`IDX_IRQEN, 8'h03);
    rr(`IDX_STATUS, 32'h08);
    chk(irq, 32'h0);
    // Select released to general use: pulling it low does nothing
    wr(`IDX_CTRL, 8'h51);
    // Pin enables are registered one edge after the control write
    repeat (2) @(posedge hclk);
    chk(select_n_oe, 32'h0);
    tb_sel <= 1'b0;
    repeat (8) @(posedge hclk);
    rr(`IDX_CTRL, 32'h51);
    rr(`IDX_STATUS, 32'h08);
    tb_sel <= 1'b1;
    wr(`IDX_CTRL, 8'h00);
    wr(`IDX_STATUS, 8'h00);
    wr(`IDX_CTRL, 8'hd0);
    repeat (2) @(posedge hclk);
    chk(select_n_oe, 32'h0);
    tb_sel <= 1'b0;
    repeat (8) @(posedge hclk);
    rr(`IDX_CTRL, 32'h80);
    rr(`IDX_STATUS, 32'h10);
    chk(irq, 32'h1);
    tb_sel <= 1'b1;
    wr(`IDX_STATUS, 8'h08);
    // Slave role driven by the bench as outside master; select output bits must not matter
    wr(`IDX_CTRL, 8'hc0);
    repeat (2) @(posedge hclk);
    chk(select_n_oe, 32'h0);
    b = $urandom;
    slv(b, 8);
    rr(`IDX_STATUS, 32'h88);
    rr(`IDX_DATA, {24'h0, b});
    wr(`IDX_STATUS, 8'h08);
    slv(8'h00, 4);
    rr(`IDX_STATUS, 32'h08);
    // Idle slave takes a write straight into its shifter; first bit shows at once
    wr(`IDX_DATA, 8'ha5);
    @(posedge hclk);
    chk(miso_o, 32'h1);
    wr(`IDX_DATA, 8'h5a);
    @(posedge hclk);
    chk(miso_o, 32'h0);
    b = $urandom;
    fork
      slv(b, 8);
      begin
        repeat (50) @(posedge hclk);
        wr(`IDX_DATA, 8'hff);
        chk(miso_oe, 32'h1);
      end
    join
    rr(`IDX_STATUS, 32'hc8);
    rr(`IDX_DATA, {24'h0, b});
    chk(mrx, 32'h5a);
    report_and_stop;
  end
endmodule
`default_nettype wire
